/* File: src/vi_pkg.sv */
// constants shared by both ends of the voltage increase sequence
package vi_pkg;
    // clock rate, period in picoseconds
    localparam int CLK_PERIOD_PS = 25000;
    // timing figures in nanoseconds
    localparam int T_SRC_TRANSITION_NS = 30000;
    localparam int T_SRC_READY_NS = 100000;
    localparam int T_SNK_STDBY_NS = 15000;
    localparam int T_PS_TRANSITION_NS = 500000;
    localparam int T_CRC_WAIT_NS = 1000;
    // least times round up, longest times round down
    localparam int SRC_TRANS_CYC = (T_SRC_TRANSITION_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SRC_READY_CYC = (T_SRC_READY_NS * 1000) / CLK_PERIOD_PS;
    localparam int SNK_STDBY_CYC = (T_SNK_STDBY_NS * 1000) / CLK_PERIOD_PS;
    localparam int PS_TRANS_CYC = (T_PS_TRANSITION_NS * 1000) / CLK_PERIOD_PS;
    localparam int CRC_WAIT_CYC = (T_CRC_WAIT_NS * 1000) / CLK_PERIOD_PS;
    // resend attempts after a missing acknowledge
    localparam int RETRY_MAX = 2;
    // timer width
    localparam int TMR_W = 16;
    // message codes on the link
    localparam int MSG_W = 2;
    localparam logic [MSG_W-1:0] MSG_NONE = 2'h0;
    localparam logic [MSG_W-1:0] MSG_ACCEPT = 2'h1;
    localparam logic [MSG_W-1:0] MSG_PS_RDY = 2'h2;
endpackage : vi_pkg

/* File: src/pd_link_if.sv */
// message link between source and sink policy engines
`timescale 1ns/1ps
interface pd_link_if import vi_pkg::*; ();
    logic msg_valid;
    logic [MSG_W-1:0] msg_type;
    logic crc_ack;
    modport source (output msg_valid, output msg_type, input crc_ack);
    modport sink (input msg_valid, input msg_type, output crc_ack);
endinterface : pd_link_if

/* File: src/tick_timer.sv */
// down-counting tick timer with one-cycle expiry pulse
`timescale 1ns/1ps
module tick_timer #(
    parameter int W = 16
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic start,
    input wire logic stop,
    input wire logic [W-1:0] load,
    output logic busy,
    output logic expired
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic busy;
        logic expired;
    } tmr_s;

    tmr_s q;
    tmr_s d;

    if (W < 2) begin : g_chk
        $error("tick_timer width too small");
    end

    // stop beats start, a restart reloads
    always_comb begin
        d = q;
        d.expired = 1'b0;
        if (stop) begin
            d.busy = 1'b0;
            d.cnt = '0;
        end else if (start) begin
            d.busy = 1'b1;
            d.cnt = load;
        end else if (q.busy) begin
            d.cnt = q.cnt - W'(1);
            if (q.cnt <= W'(1)) begin
                d.busy = 1'b0;
                d.expired = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            q <= '0;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign busy = q.busy;
    assign expired = q.expired;
endmodule : tick_timer

/* File: src/source_seq.sv */
// source policy engine for a voltage increase transition
// Operation
// [R1] grant sends Accept to the sink
// [R2] sink starts transition timer on Accept
// [R3] sink acknowledges Accept, then evaluates it
// [R4] after Accept acknowledge, wait source transition time
// [R5] sink drops to standby within standby time
// [R6] sink standby done before transition time ends
// [R7] sink keeps load steps within transient limits; sink_seq does not limit load steps and leaves load slew to the supply
// [R8] transition over, command supply to new voltage
// [R9] supply ready within ready time of command
// [R10] supply readiness reaches the policy engine
// [R11] readiness seen, send PS_RDY to sink
// [R12] sink acknowledges PS_RDY, then permits new power
// [R13] sink raises load only after PS_RDY evaluated
// [R14] sink settling time varies with load step
// [R15] state machines with tick timers gate each step
`timescale 1ns/1ps
module source_seq import vi_pkg::*; #(
    parameter int SRC_TRANS = SRC_TRANS_CYC,
    parameter int SRC_READY = SRC_READY_CYC,
    parameter int CRC_WAIT = CRC_WAIT_CYC,
    parameter int RETRIES = RETRY_MAX
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // pulse: grant the sink's pending request
    input wire logic grant,
    // level: supply reports ready at new level
    input wire logic supply_ready,
    pd_link_if.source link,
    // level: command supply to new voltage
    output logic supply_change,
    output logic busy,
    output logic seq_done,
    output logic crc_fail,
    output logic ready_late
);
    typedef enum logic [2:0] {
        S_IDLE,
        S_ACC_CRC,
        S_TRANSITION,
        S_SUPPLY,
        S_RDY_CRC
    } src_state_e;

    typedef struct packed {
        src_state_e st;
        logic msg_valid;
        logic [MSG_W-1:0] msg_type;
        logic supply_change;
        logic busy;
        logic seq_done;
        logic crc_fail;
        logic ready_late;
        logic [1:0] tries;
    } src_s;

    localparam src_s SRC_RST = '{st: S_IDLE, default: '0};

    src_s q;
    src_s d;
    logic tmr_start;
    logic tmr_stop;
    logic [TMR_W-1:0] tmr_load;
    logic tmr_busy;
    logic tmr_exp;

    // refuse counts that the timer or the two-bit tries counter cannot hold
    if (SRC_TRANS < 1 || SRC_TRANS >= 2 ** TMR_W) begin : g_chk_trans
        $error("SRC_TRANS out of range");
    end
    if (SRC_READY < 1 || SRC_READY >= 2 ** TMR_W) begin : g_chk_ready
        $error("SRC_READY out of range");
    end
    if (CRC_WAIT < 2 || CRC_WAIT >= 2 ** TMR_W) begin : g_chk_crc
        $error("CRC_WAIT out of range");
    end
    if (RETRIES < 0 || RETRIES > 3) begin : g_chk_retry
        $error("RETRIES out of range");
    end

    // one timer serves every step, since the steps never overlap
    tick_timer #(
        .W(TMR_W)
    ) u_tmr (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .start(tmr_start),
        .stop(tmr_stop),
        .load(tmr_load),
        .busy(tmr_busy),
        .expired(tmr_exp)
    );

    // sequence steps, each waits for its acknowledge or timer, the supply step for supply readiness
    always_comb begin
        d = q;
        d.msg_valid = 1'b0;
        d.msg_type = MSG_NONE;
        d.seq_done = 1'b0;
        d.crc_fail = 1'b0;
        tmr_start = 1'b0;
        tmr_stop = 1'b0;
        tmr_load = TMR_W'(CRC_WAIT);
        case (q.st)
            S_IDLE: begin
                // grant while busy is ignored, one contract at a time
                if (grant) begin
                    d.msg_valid = 1'b1; // see [R1]
                    d.msg_type = MSG_ACCEPT;
                    d.ready_late = 1'b0;
                    d.tries = '0;
                    d.busy = 1'b1;
                    tmr_start = 1'b1;
                    d.st = S_ACC_CRC; // see [R15]
                end
            end
            S_ACC_CRC: begin
                if (link.crc_ack) begin
                    // acknowledge starts the transition wait
                    tmr_load = TMR_W'(SRC_TRANS); // see [R4]
                    tmr_start = 1'b1;
                    d.st = S_TRANSITION;
                end else if (tmr_exp) begin
                    if (q.tries < 2'(RETRIES)) begin
                        // resend, the sink may have missed it
                        d.msg_valid = 1'b1;
                        d.msg_type = MSG_ACCEPT;
                        d.tries = q.tries + 2'h1;
                        tmr_start = 1'b1;
                    end else begin
                        d.crc_fail = 1'b1;
                        d.busy = 1'b0;
                        d.st = S_IDLE;
                    end
                end
            end
            S_TRANSITION: begin
                // the sink uses this interval to reach standby
                if (tmr_exp) begin
                    d.supply_change = 1'b1; // see [R8]
                    tmr_load = TMR_W'(SRC_READY);
                    tmr_start = 1'b1;
                    d.st = S_SUPPLY;
                end
            end
            S_SUPPLY: begin
                if (supply_ready) begin
                    // readiness passed on, announce it
                    d.msg_valid = 1'b1; // see [R10] [R11]
                    d.msg_type = MSG_PS_RDY;
                    d.supply_change = 1'b0;
                    d.tries = '0;
                    tmr_load = TMR_W'(CRC_WAIT);
                    tmr_start = 1'b1;
                    d.st = S_RDY_CRC;
                end else if (tmr_exp) begin
                    // late supply is flagged, the wait goes on
                    d.ready_late = 1'b1; // see [R9]
                end
            end
            S_RDY_CRC: begin
                if (link.crc_ack) begin
                    tmr_stop = 1'b1;
                    d.seq_done = 1'b1; // see [R15]
                    d.busy = 1'b0;
                    d.st = S_IDLE;
                end else if (tmr_exp) begin
                    if (q.tries < 2'(RETRIES)) begin
                        d.msg_valid = 1'b1;
                        d.msg_type = MSG_PS_RDY;
                        d.tries = q.tries + 2'h1;
                        tmr_start = 1'b1;
                    end else begin
                        d.crc_fail = 1'b1;
                        d.busy = 1'b0;
                        d.st = S_IDLE;
                    end
                end
            end
            default: begin
                d = SRC_RST;
                tmr_stop = 1'b1;
            end
        endcase
    end

    // state register, frozen while clk_en is low
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            q <= SRC_RST;
        end else if (clk_en) begin
            q <= d;
        end
    end

    // every output straight from the state register
    assign link.msg_valid = q.msg_valid;
    assign link.msg_type = q.msg_type;
    assign supply_change = q.supply_change;
    assign busy = q.busy;
    assign seq_done = q.seq_done;
    assign crc_fail = q.crc_fail;
    assign ready_late = q.ready_late;
endmodule : source_seq

/* File: src/sink_seq.sv */
// sink policy engine for a voltage increase transition
`timescale 1ns/1ps
module sink_seq import vi_pkg::*; #(
    parameter int SNK_STDBY = SNK_STDBY_CYC,
    parameter int PS_TRANS = PS_TRANS_CYC
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    pd_link_if.sink link,
    // level: draw has fallen to standby
    input wire logic standby_reached,
    output logic standby_req,
    output logic new_power_ok,
    output logic ps_timer_run,
    output logic ps_timer_expired,
    output logic standby_late
);
    typedef enum logic [2:0] {
        K_IDLE,
        K_ACC_EVAL,
        K_STANDBY,
        K_WAIT_RDY,
        K_RDY_EVAL
    } snk_state_e;

    typedef struct packed {
        snk_state_e st;
        logic crc_ack;
        logic standby_req;
        logic new_power_ok;
        logic ps_expired;
        logic standby_late;
    } snk_s;

    localparam snk_s SNK_RST = '{st: K_IDLE, default: '0};

    snk_s q;
    snk_s d;
    logic ps_start;
    logic ps_stop;
    logic ps_busy;
    logic ps_exp;
    logic sb_start;
    logic sb_stop;
    logic sb_exp;
    logic got_acc;
    logic got_rdy;

    if (SNK_STDBY < 1 || SNK_STDBY >= 2 ** TMR_W) begin : g_chk_sb
        $error("SNK_STDBY out of range");
    end
    if (PS_TRANS < 1 || PS_TRANS >= 2 ** TMR_W) begin : g_chk_ps
        $error("PS_TRANS out of range");
    end

    // supply transition watchdog
    tick_timer #(
        .W(TMR_W)
    ) u_ps_tmr (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .start(ps_start),
        .stop(ps_stop),
        .load(TMR_W'(PS_TRANS)),
        .busy(ps_busy),
        .expired(ps_exp)
    );

    // standby deadline
    tick_timer #(
        .W(TMR_W)
    ) u_sb_tmr (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .start(sb_start),
        .stop(sb_stop),
        .load(TMR_W'(SNK_STDBY)),
        .busy(),
        .expired(sb_exp)
    );

    assign got_acc = link.msg_valid && link.msg_type == MSG_ACCEPT;
    assign got_rdy = link.msg_valid && link.msg_type == MSG_PS_RDY;

    // acknowledge first, evaluate one cycle later
    always_comb begin
        d = q;
        d.crc_ack = link.msg_valid; // see [R3] [R12]
        ps_start = 1'b0;
        ps_stop = 1'b0;
        sb_start = 1'b0;
        sb_stop = 1'b0;
        case (q.st)
            K_IDLE: begin
                if (got_acc) begin
                    ps_start = 1'b1; // see [R2]
                    d.ps_expired = 1'b0;
                    d.standby_late = 1'b0;
                    d.new_power_ok = 1'b0;
                    d.st = K_ACC_EVAL; // see [R15]
                end
            end
            K_ACC_EVAL: begin
                // draw must fall before the source moves the voltage
                d.standby_req = 1'b1; // see [R5] [R6]
                sb_start = 1'b1;
                d.st = K_STANDBY;
            end
            K_STANDBY: begin
                // load slew is left to the supply, limits apply there
                if (got_rdy) begin
                    sb_stop = 1'b1;
                    ps_stop = 1'b1;
                    d.st = K_RDY_EVAL;
                end else if (standby_reached) begin
                    sb_stop = 1'b1; // see [R7]
                    d.st = K_WAIT_RDY;
                end else if (sb_exp) begin
                    d.standby_late = 1'b1; // see [R6]
                end
            end
            K_WAIT_RDY: begin
                if (got_rdy) begin
                    ps_stop = 1'b1;
                    d.st = K_RDY_EVAL;
                end
            end
            K_RDY_EVAL: begin
                // new load permitted only from here, settling time open
                d.new_power_ok = 1'b1; // see [R13] [R14]
                d.standby_req = 1'b0;
                d.st = K_IDLE;
            end
            default: begin
                d = SNK_RST;
                ps_stop = 1'b1;
                sb_stop = 1'b1;
            end
        endcase
        // after the case, so an expiry beats a clear in the same cycle
        if (ps_exp) begin
            // expiry is only reported, recovery lies elsewhere
            d.ps_expired = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            q <= SNK_RST;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign link.crc_ack = q.crc_ack;
    assign standby_req = q.standby_req;
    assign new_power_ok = q.new_power_ok;
    assign ps_timer_run = ps_busy;
    assign ps_timer_expired = q.ps_expired;
    assign standby_late = q.standby_late;
endmodule : sink_seq

/* File: tb/vi_monitor.sv */
// concurrent checks on the link joining source and sink engines
`timescale 1ns/1ps
module vi_monitor import vi_pkg::*; #(
    parameter int SRC_TRANS = 8
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic msg_valid,
    input wire logic [MSG_W-1:0] msg_type,
    input wire logic crc_ack,
    input wire logic grant,
    input wire logic busy,
    input wire logic supply_ready,
    input wire logic supply_change,
    input wire logic seq_done,
    input wire logic standby_req,
    input wire logic new_power_ok,
    input wire logic ps_timer_run
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // timer reload edge plus its count; the command flop shows one edge later
    localparam int TR_WAIT = SRC_TRANS + 1;

    // grant taken only when idle
    a_accept_on_grant: assert property (grant && !busy |=> busy && msg_valid && msg_type == MSG_ACCEPT)
        else $error("accept not sent after grant");
    a_ack_follows_msg: assert property (msg_valid |=> crc_ack && !msg_valid)
        else $error("message not acknowledged next cycle");
    a_ack_has_cause: assert property (crc_ack |-> $past(msg_valid))
        else $error("acknowledge without message");
    // accept acknowledge is followed by standby and the running sink transition timer
    a_standby_start: assert property ($past(msg_valid && msg_type == MSG_ACCEPT) && crc_ack
        |=> standby_req && ps_timer_run)
        else $error("sink did not start standby and timer");
    a_transition_wait: assert property ($past(msg_valid && msg_type == MSG_ACCEPT) && crc_ack
        |-> ##TR_WAIT !supply_change ##1 supply_change)
        else $error("supply command not at transition end");
    a_ready_answer: assert property (supply_change && supply_ready
        |=> msg_valid && msg_type == MSG_PS_RDY && !supply_change)
        else $error("readiness not forwarded as ps ready");
    a_ps_rdy_cause: assert property (msg_valid && msg_type == MSG_PS_RDY
        |-> $past(supply_ready && supply_change))
        else $error("ps ready without supply readiness");
    a_done_after_ack: assert property ($past(msg_valid && msg_type == MSG_PS_RDY) && crc_ack
        |=> seq_done && !busy && new_power_ok && !standby_req)
        else $error("ps ready acknowledge did not finish");
    a_no_early_power: assert property ($rose(new_power_ok) |-> $past(crc_ack))
        else $error("new power allowed before ps ready");
endmodule : vi_monitor

/* File: tb/test_source_voltage_increase_sequencer.sv */
// testbench joining both engines over one link, plus a link that never acknowledges
`timescale 1ns/1ps
module test_source_voltage_increase_sequencer import vi_pkg::*;;
    localparam int T_TR = 8;
    localparam int T_PS = 50;
    localparam int N_RETRY = 2;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic clk_en = 1'b1;
    logic grant = 1'b0;
    logic grant_b = 1'b0;
    logic supply_ready = 1'b0;
    logic standby_reached = 1'b0;
    logic supply_change, busy, seq_done, crc_fail, ready_late, crc_fail_b;
    logic standby_req, new_power_ok, ps_timer_run, ps_timer_expired, standby_late;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int rdy_delay = 0;
    int sb_delay = 0;
    int rdy_cnt = 0;
    int sb_cnt = 0;
    int msgs = 0;
    int resends = 0;
    pd_link_if link();
    pd_link_if link_b();

    source_seq #(.SRC_TRANS(T_TR), .SRC_READY(20), .CRC_WAIT(4), .RETRIES(N_RETRY)) source_seq_i (
        .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .grant(grant), .supply_ready(supply_ready),
        .link(link.source), .supply_change(supply_change), .busy(busy), .seq_done(seq_done),
        .crc_fail(crc_fail), .ready_late(ready_late));
    sink_seq #(.SNK_STDBY(4), .PS_TRANS(T_PS)) sink_seq_i (
        .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .link(link.sink),
        .standby_reached(standby_reached), .standby_req(standby_req), .new_power_ok(new_power_ok),
        .ps_timer_run(ps_timer_run), .ps_timer_expired(ps_timer_expired), .standby_late(standby_late));
    vi_monitor #(.SRC_TRANS(T_TR)) vi_monitor_i (
        .ref_clk(ref_clk), .nrst(nrst), .msg_valid(link.msg_valid), .msg_type(link.msg_type),
        .crc_ack(link.crc_ack), .grant(grant), .busy(busy), .supply_ready(supply_ready),
        .supply_change(supply_change), .seq_done(seq_done), .standby_req(standby_req),
        .new_power_ok(new_power_ok), .ps_timer_run(ps_timer_run));

    // faulty far end: never acknowledges, so resends and give-up are reachable
    assign link_b.crc_ack = 1'b0;
    if (1) begin : fault_end
        source_seq #(.SRC_TRANS(T_TR), .SRC_READY(20), .CRC_WAIT(4), .RETRIES(N_RETRY)) source_seq_i (
            .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .grant(grant_b), .supply_ready(supply_ready),
            .link(link_b.source), .supply_change(), .busy(), .seq_done(), .crc_fail(crc_fail_b),
            .ready_late());
    end

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    // supply and load models answer after programmed delays
    always @(negedge ref_clk) begin
        rdy_cnt <= supply_change ? rdy_cnt + 1 : 0;
        supply_ready <= supply_change && (rdy_cnt >= rdy_delay);
        sb_cnt <= standby_req ? sb_cnt + 1 : 0;
        standby_reached <= standby_req && (sb_cnt >= sb_delay);
    end

    // message counters and hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (link.msg_valid === 1'b1) msgs <= msgs + 1;
        if (link_b.msg_valid === 1'b1) resends <= resends + 1;
        if (cycles == 3000) begin
            errors++;
            $display("[ERR] %0t timeout", $time);
            tally_and_finish();
        end
    end

    task automatic chk_bit(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask : chk_bit

    task automatic chk_num(input int got, input int exp, input string what);
        cmp_count++;
        if (got != exp) begin
            errors++;
            $display("[ERR] %0t %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask : chk_num

    // one full transition; a second grant mid-way must be ignored
    task automatic transfer(input int rdy, input int sb, output int rise_at);
        int n;
        rdy_delay = rdy;
        sb_delay = sb;
        msgs = 0;
        grant = 1'b1;
        @(negedge ref_clk);
        n = 1;
        grant = 1'b0;
        while (supply_change !== 1'b1 && n < 300) begin
            @(negedge ref_clk);
            n++;
            grant = (n == 5);
        end
        rise_at = n;
        chk_bit(new_power_ok, 1'b0, "power allowed early");
        while (seq_done !== 1'b1 && n < 600) begin
            @(negedge ref_clk);
            n++;
        end
        chk_bit(new_power_ok, 1'b1, "power not allowed");
        chk_num(msgs, 2, "messages per transition");
        @(negedge ref_clk);
    endtask : transfer

    task automatic tally_and_finish();
        if (errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        int rise;
        int n;
        repeat (12) @(negedge ref_clk);
        nrst = 1'b1;
        // prompt supply and load
        transfer(2, 1, rise);
        // grant edge, ack edge, reload edge, then the full count and the command edge
        chk_num(rise, 4 + T_TR, "supply command delay");
        chk_bit(ready_late, 1'b0, "ready late prompt");
        chk_bit(standby_late, 1'b0, "standby late prompt");
        chk_bit(ps_timer_expired, 1'b0, "ps timer prompt");
        // slow supply trips the ready flag and the sink timer
        transfer(T_PS + 10, 1, rise);
        chk_bit(ready_late, 1'b1, "ready late slow");
        chk_bit(ps_timer_expired, 1'b1, "ps timer slow");
        // slow load misses the standby deadline; old flags cleared
        transfer(2, 10, rise);
        chk_bit(standby_late, 1'b1, "standby late slow");
        chk_bit(ready_late, 1'b0, "ready late cleared");
        chk_bit(ps_timer_expired, 1'b0, "ps timer cleared");
        // missing acknowledge: resend, then give up; a freeze must hold the ack timer
        resends = 0;
        grant_b = 1'b1;
        @(negedge ref_clk);
        grant_b = 1'b0;
        @(negedge ref_clk);
        clk_en = 1'b0;
        repeat (10) @(negedge ref_clk);
        chk_num(resends, 1, "resend while frozen");
        clk_en = 1'b1;
        n = 0;
        while (crc_fail_b !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        chk_bit(crc_fail_b, 1'b1, "give up without ack");
        chk_num(resends, N_RETRY + 1, "accept attempts");
        tally_and_finish();
    end
endmodule : test_source_voltage_increase_sequencer
